// ---- pfc_consts.svh ----
// Purpose: shared constants of the packet filter and dc-free codec
// Assumes: included by bare name; definitions only
// Notes: field positions and encodings named here, types live in pfc_pkg
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

`define PFC_FILT_OFF 2'b00
`define PFC_FILT_NODE 2'b01
`define PFC_FILT_ZERO 2'b10
`define PFC_FILT_BOTH 2'b11
`define PFC_ADDR_ZERO 8'h00
`define PFC_ADDR_ONES 8'hff
`define PFC_CRC_POLY 16'h1021
`define PFC_CRC_PRESET 16'hffff
`define PFC_WHT_PRESET 9'h1ff
`define PFC_WHT_TAP 5
`define PFC_ALL_ONES32 32'hffffffff
`define PFC_PH_DATA 2'b00
`define PFC_PH_CRC_HI 2'b01
`define PFC_PH_CRC_LO 2'b10
`define PFC_BYTE_BITS 6'h08
`define PFC_LAST_BIT 3'h7

`endif

// ---- pfc_crc_whiten.sv ----
// Purpose: checksum register and scrambler lfsr shared by tx and rx
// Assumes: caller feeds plain nrz bits, msb first
// Notes: half duplex, so one instance serves both directions
`timescale 1ns/10ps
`include "pfc_consts.svh"
module pfc_crc_whiten (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic init_i,
    input wire logic crc_step_i,
    input wire logic wht_step_i,
    input wire logic data_bit_i,
    output logic [15:0] crc_o,
    output logic wht_bit_o
);
    import pfc_pkg::*;

    logic [15:0] crc_q, crc_d;  // running checksum
    logic [8:0] wht_q, wht_d;   // scrambler state
    logic fb;                   // checksum feedback

    // next state: preset on init, else step on request
    always_comb begin
        crc_d = crc_q;
        wht_d = wht_q;
        fb = crc_q[15] ^ data_bit_i;
        if (init_i) begin
            crc_d = `PFC_CRC_PRESET;
            wht_d = `PFC_WHT_PRESET;
        end else begin
            // preset of ones makes leading zeros change the result
            if (crc_step_i) begin
                crc_d = {crc_q[14:0], 1'b0} ^ (fb ? `PFC_CRC_POLY : 16'h0000);
            end
            if (wht_step_i) begin
                wht_d = {wht_q[0] ^ wht_q[`PFC_WHT_TAP], wht_q[8:1]};
            end
        end
    end

    // registers only
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            crc_q <= `PFC_CRC_PRESET;
            wht_q <= `PFC_WHT_PRESET;
        end else begin
            crc_q <= crc_d;
            wht_q <= wht_d;
        end
    end

    assign crc_o = crc_q;
    assign wht_bit_o = wht_q[0];
endmodule

// ---- pfc_handler_properties.sv ----
// Purpose: port checks of the packet handler
// Assumes: one clock, rst_i async active high
// Notes: bound below to every handler instance
`timescale 1ns/10ps
module pfc_handler_properties (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire pfc_pkg::pfc_cfg_t cfg_i,
    input wire logic rx_mode_i,
    input wire logic tx_start_i,
    input wire logic tx_chip_o,
    input wire logic tx_active_o,
    input wire logic rx_byte_valid_o,
    input wire pfc_pkg::pfc_evt_t events_o,
    input wire logic checksum_result_flag_o
);
    import pfc_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_ok_with_ready: assert property (events_o.checksum_ok_event |->
        events_o.payload_ready_event ##1 checksum_result_flag_o) else $error("ok alone");
    a_clear_alone: assert property (events_o.fifo_clear |->
        !events_o.payload_ready_event && !events_o.checksum_ok_event) else $error("clear");
    a_flag_at_compare: assert property ($changed(checksum_result_flag_o) |->
        events_o.payload_ready_event || events_o.fifo_clear) else $error("flag moved");
    a_sync_in_rx: assert property (events_o.sync_event |->
        $past(rx_mode_i) && cfg_i.sync_match_enable) else $error("stray sync");
    a_start_answer: assert property (tx_start_i && !tx_active_o && !rx_mode_i
        |=> tx_active_o) else $error("no start");
    a_chip_hold: assert property ($changed(tx_chip_o) && cfg_i.bit_rate_value != 7'h00
        |=> $stable(tx_chip_o)) else $error("short chip");
    a_byte_spacing: assert property (rx_byte_valid_o |=> !rx_byte_valid_o [*7])
        else $error("bytes too close");
    a_done_active: assert property (events_o.tx_done |-> $fell(tx_active_o))
        else $error("done not at frame end");
    c_accept: cover property (events_o.checksum_ok_event);
    c_discard: cover property (events_o.fifo_clear);
    c_kept_fail: cover property (events_o.payload_ready_event && !events_o.checksum_ok_event);
endmodule
bind pfc_packet_handler pfc_handler_properties i_pfc_handler_properties (.clk_sys_i, .rst_i,
    .cfg_i, .rx_mode_i, .tx_start_i, .tx_chip_o, .tx_active_o, .rx_byte_valid_o, .events_o,
    .checksum_result_flag_o);

// ---- pfc_modem_model.sv ----
// Purpose: modem stand-in recording tx chips and replaying them to rx
// Assumes: a chip stands at least two clocks
// Notes: the released line toggles each clock so no stale chip is seen
`timescale 1ns/10ps
module pfc_modem_model (
    input wire logic clk_sys_i,
    input wire logic rec_i,
    input wire logic play_i,
    input wire logic flip_i,
    input wire logic chip_i,
    output logic chip_o
);
    logic q[$]; // chip line, one entry per clock
    int idx = 0;
    initial chip_o = 1'b0;
    task automatic clear();
        q.delete();
    endtask
    // replay; two clocks flipped near the end hit exactly one sampled chip
    always @(posedge clk_sys_i) begin
        if (rec_i) q.push_back(chip_i);
        if (play_i && idx < q.size() + 4) begin
            chip_o <= idx >= q.size() ? q[$] : q[idx] ^ (flip_i && q.size() - idx inside {7, 8});
            idx <= idx + 1;
        end else begin
            chip_o <= ~chip_o;
            idx <= play_i ? idx : 0;
        end
    end
endmodule

// ---- pfc_packet_handler.sv ----
// Purpose: packet filtering, checksum and dc-free coding between fifo and modem
// Assumes: fifo side on clk_sys_i; rx chip line is a pin
// Notes: half duplex; rx_mode_i selects the direction
`timescale 1ns/10ps
`include "pfc_consts.svh"
module pfc_packet_handler (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire pfc_pkg::pfc_cfg_t cfg_i,
    input wire logic rx_mode_i,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_byte_valid_i,
    output logic tx_byte_ready_o,
    output logic tx_chip_o,
    output logic tx_active_o,
    input wire logic rx_chip_i,
    output logic [7:0] rx_byte_o,
    output logic rx_byte_valid_o,
    output pfc_pkg::pfc_evt_t events_o,
    output logic checksum_result_flag_o
);
    import pfc_pkg::*;

    // chip timer and pin synchroniser
    logic [6:0] tick_q, tick_d;  // chip period down counter
    logic tick;                  // one chip period elapsed
    logic rx_meta_q, rx_chip_q;  // two-stage pin synchroniser

    // sync word geometry, common to both directions
    logic [4:0] sync_shift;      // (3 - size) * 8
    logic [5:0] sync_bits;       // sync word length in bits
    logic [31:0] sync_mask;
    logic [31:0] sync_exp;       // right aligned expected word

    // codec shared by both directions
    logic c_init, c_crc, c_wht, c_bit;
    logic t_init, t_crc, t_wht, t_bit;
    logic r_init, r_crc, r_wht, r_bit;
    logic [15:0] crc;
    logic wbit;

    // transmit state
    pfc_tx_state_t tst_q, tst_d;
    logic [31:0] tsh_q, tsh_d;   // sync and byte shifter, msb first
    logic [5:0] tbit_q, tbit_d;  // bits left in current field
    logic [7:0] tidx_q, tidx_d;  // payload byte index
    logic [7:0] ttot_q, ttot_d;  // payload byte total
    logic [1:0] tph_q, tph_d;    // data or checksum phase
    logic thalf_q, thalf_d;      // second biphase chip pending
    logic tcode_q, tcode_d;      // coded bit of current biphase pair
    logic tchip_q, tchip_d;
    logic tdone_q, tdone_d;
    logic tlen, tcoded, tadv;

    // receive state
    pfc_rx_state_t rst_q, rst_d;
    logic [31:0] rsh_q, rsh_d;   // hunt window
    logic [7:0] rbyte_q, rbyte_d;
    logic [2:0] rbit_q, rbit_d;
    logic [7:0] ridx_q, ridx_d;
    logic [7:0] rtot_q, rtot_d;
    logic [1:0] rph_q, rph_d;
    logic [7:0] rhi_q, rhi_d;    // received checksum high byte
    logic rhalf_q, rhalf_d;      // skip second biphase chip
    logic rflag_q, rflag_d;
    logic [7:0] rout_q, rout_d;
    logic rval_q, rval_d;
    pfc_evt_t revt_q, revt_d;
    logic [5:0] errs;            // sync bit errors in window
    logic [31:0] rwin;
    logic [7:0] b;               // completed byte
    logic [7:0] tot_eff;
    logic rlen, rplain, rtake, addr_ok, discard;

    // geometry: one configuration drives insert and filter
    always_comb begin
        sync_shift = {~cfg_i.sync_word_size, 3'b000};
        sync_bits = {({1'b0, cfg_i.sync_word_size} + 3'h1), 3'b000};
        sync_mask = `PFC_ALL_ONES32 >> sync_shift;
        sync_exp = cfg_i.sync_word_value >> sync_shift;
    end

    // chip timer: free running so rate stays fixed across all fields
    always_comb begin
        tick = (tick_q == 7'h00);
        tick_d = tick ? cfg_i.bit_rate_value : tick_q - 7'h01;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tick_q <= 7'h00;
            rx_meta_q <= 1'b0;
            rx_chip_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            rx_meta_q <= rx_chip_i;
            rx_chip_q <= rx_meta_q;
        end
    end

    // shared codec: tx owns it while a frame is out, else rx
    always_comb begin
        // tx presets while still idle when no sync word goes out, so take either side
        c_init = t_init || r_init;
        c_crc = tx_active_o ? t_crc : r_crc;
        c_wht = tx_active_o ? t_wht : r_wht;
        c_bit = tx_active_o ? t_bit : r_bit;
    end

    pfc_crc_whiten u_codec (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .init_i(c_init),
        .crc_step_i(c_crc),
        .wht_step_i(c_wht),
        .data_bit_i(c_bit),
        .crc_o(crc),
        .wht_bit_o(wbit)
    );

    // transmit next state
    always_comb begin
        tst_d = tst_q;
        tsh_d = tsh_q;
        tbit_d = tbit_q;
        tidx_d = tidx_q;
        ttot_d = ttot_q;
        tph_d = tph_q;
        thalf_d = thalf_q;
        tcode_d = tcode_q;
        tchip_d = tchip_q;
        tdone_d = 1'b0;
        tx_byte_ready_o = 1'b0;
        t_init = 1'b0;
        t_crc = 1'b0;
        t_wht = 1'b0;
        t_bit = tsh_q[31];
        tadv = 1'b0;
        // length byte is scrambled but kept out of the checksum
        tlen = cfg_i.variable_length && tidx_q == 8'h00 && tph_q == `PFC_PH_DATA;
        tcoded = tsh_q[31] ^ (cfg_i.scrambler_enable & wbit);
        case (tst_q)
            TX_IDLE: begin
                if (tx_start_i && !rx_mode_i) begin
                    tsh_d = cfg_i.sync_word_value; // top bytes go out first
                    tbit_d = sync_bits;
                    tidx_d = 8'h00;
                    ttot_d = {1'b0, cfg_i.payload_length_limit};
                    tph_d = `PFC_PH_DATA;
                    thalf_d = 1'b0;
                    if (cfg_i.sync_match_enable) begin
                        tst_d = TX_SYNC;
                    end else begin
                        t_init = 1'b1;
                        tst_d = TX_LOAD;
                    end
                end
            end
            TX_SYNC: begin
                // sync chips go out plain nrz
                if (tick) begin
                    tchip_d = tsh_q[31];
                    tsh_d = tsh_q << 1;
                    tbit_d = tbit_q - 6'h01;
                    if (tbit_q == 6'h01) begin
                        t_init = 1'b1;
                        tst_d = TX_LOAD;
                    end
                end
            end
            TX_LOAD: begin
                tbit_d = `PFC_BYTE_BITS;
                if (tph_q == `PFC_PH_DATA) begin
                    // host stalls the line if the fifo runs dry
                    tx_byte_ready_o = 1'b1;
                    if (tx_byte_valid_i) begin
                        tsh_d = {tx_byte_i, 24'h000000};
                        if (tlen) begin
                            ttot_d = tx_byte_i + 8'h01;
                        end
                        tst_d = TX_BITS;
                    end
                end else if (tph_q == `PFC_PH_CRC_HI) begin
                    tsh_d = {~crc[15:8], 24'h000000};
                    tst_d = TX_BITS;
                end else begin
                    tsh_d = {~crc[7:0], 24'h000000};
                    tst_d = TX_BITS;
                end
            end
            TX_BITS: begin
                if (tick && !thalf_q) begin
                    tchip_d = tcoded;
                    t_wht = 1'b1;
                    t_crc = cfg_i.checksum_enable && tph_q == `PFC_PH_DATA && !tlen;
                    if (cfg_i.biphase_coding_enable) begin
                        thalf_d = 1'b1;
                        tcode_d = tcoded;
                    end else begin
                        tadv = 1'b1;
                    end
                end else if (tick) begin
                    tchip_d = ~tcode_q;
                    thalf_d = 1'b0;
                    tadv = 1'b1;
                end
                if (tadv) begin
                    tsh_d = tsh_q << 1;
                    tbit_d = tbit_q - 6'h01;
                    if (tbit_q == 6'h01) begin
                        tst_d = TX_LOAD;
                        if (tph_q == `PFC_PH_DATA && tidx_q + 8'h01 != ttot_q) begin
                            tidx_d = tidx_q + 8'h01;
                        end else if (tph_q == `PFC_PH_DATA && cfg_i.checksum_enable) begin
                            tph_d = `PFC_PH_CRC_HI;
                        end else if (tph_q == `PFC_PH_CRC_HI) begin
                            tph_d = `PFC_PH_CRC_LO;
                        end else begin
                            tst_d = TX_DONE;
                        end
                    end
                end
            end
            TX_DONE: begin
                tdone_d = 1'b1;
                tst_d = TX_IDLE;
            end
            default: tst_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tst_q <= TX_IDLE;
            tsh_q <= 32'h00000000;
            tbit_q <= 6'h00;
            tidx_q <= 8'h00;
            ttot_q <= 8'h00;
            tph_q <= `PFC_PH_DATA;
            thalf_q <= 1'b0;
            tcode_q <= 1'b0;
            tchip_q <= 1'b0;
            tdone_q <= 1'b0;
        end else begin
            tst_q <= tst_d;
            tsh_q <= tsh_d;
            tbit_q <= tbit_d;
            tidx_q <= tidx_d;
            ttot_q <= ttot_d;
            tph_q <= tph_d;
            thalf_q <= thalf_d;
            tcode_q <= tcode_d;
            tchip_q <= tchip_d;
            tdone_q <= tdone_d;
        end
    end

    // receive next state
    always_comb begin
        rst_d = rst_q;
        rsh_d = rsh_q;
        rbyte_d = rbyte_q;
        rbit_d = rbit_q;
        ridx_d = ridx_q;
        rtot_d = rtot_q;
        rph_d = rph_q;
        rhi_d = rhi_q;
        rhalf_d = rhalf_q;
        rflag_d = rflag_q;
        rout_d = rout_q;
        rval_d = 1'b0;
        revt_d = '0;
        r_init = 1'b0;
        r_crc = 1'b0;
        r_wht = 1'b0;
        discard = 1'b0;
        rwin = {rsh_q[30:0], rx_chip_q};
        errs = 6'h00;
        for (int i = 0; i < 32; i++) begin
            errs = errs + {5'h00, (rwin[i] ^ sync_exp[i]) & sync_mask[i]};
        end
        rplain = rx_chip_q ^ (cfg_i.scrambler_enable & wbit);
        r_bit = rplain;
        b = {rbyte_q[6:0], rplain};
        rlen = cfg_i.variable_length && ridx_q == 8'h00 && rph_q == `PFC_PH_DATA;
        tot_eff = rlen ? b + 8'h01 : rtot_q;
        // first chip of a biphase pair carries the bit, second is skipped
        rtake = !cfg_i.biphase_coding_enable || !rhalf_q;
        addr_ok = b == cfg_i.node_address
            || (cfg_i.address_filter_mode[1] && b == `PFC_ADDR_ZERO)
            || (cfg_i.address_filter_mode == `PFC_FILT_BOTH && b == `PFC_ADDR_ONES);
        case (rst_q)
            RX_IDLE: begin
                if (rx_mode_i && !tx_active_o && cfg_i.sync_match_enable) begin
                    rsh_d = ~sync_exp;
                    rst_d = RX_HUNT;
                end
            end
            RX_HUNT: begin
                // no match means no event and nothing stored
                if (!rx_mode_i) begin
                    rst_d = RX_IDLE;
                end else if (tick) begin
                    rsh_d = rwin;
                    if (errs <= {4'h0, cfg_i.sync_error_tolerance}) begin
                        revt_d.sync_event = 1'b1;
                        r_init = 1'b1;
                        ridx_d = 8'h00;
                        rtot_d = {1'b0, cfg_i.payload_length_limit};
                        rph_d = `PFC_PH_DATA;
                        rbit_d = 3'h0;
                        rhalf_d = 1'b0;
                        rst_d = RX_BITS;
                    end
                end
            end
            RX_BITS: begin
                if (!rx_mode_i) begin
                    rst_d = RX_IDLE;
                end else if (tick && !rtake) begin
                    rhalf_d = 1'b0;
                end else if (tick) begin
                    rhalf_d = cfg_i.biphase_coding_enable;
                    r_wht = 1'b1;
                    r_crc = cfg_i.checksum_enable && rph_q == `PFC_PH_DATA && !rlen;
                    rbyte_d = b;
                    rbit_d = rbit_q + 3'h1;
                    if (rbit_q == `PFC_LAST_BIT) begin
                        if (rph_q == `PFC_PH_DATA) begin
                            if (rlen && b >= {1'b0, cfg_i.payload_length_limit}) begin
                                discard = 1'b1;
                            end
                            if (ridx_q == {7'h00, cfg_i.variable_length}
                                && cfg_i.address_filter_mode != `PFC_FILT_OFF && !addr_ok) begin
                                discard = 1'b1;
                            end
                            if (!discard) begin
                                rout_d = b;
                                rval_d = 1'b1;
                                rtot_d = tot_eff;
                                ridx_d = ridx_q + 8'h01;
                                if (ridx_q + 8'h01 == tot_eff) begin
                                    if (cfg_i.checksum_enable) begin
                                        rph_d = `PFC_PH_CRC_HI;
                                    end else begin
                                        revt_d.payload_ready_event = 1'b1;
                                        rsh_d = ~sync_exp;
                                        rst_d = RX_HUNT;
                                    end
                                end
                            end
                        end else if (rph_q == `PFC_PH_CRC_HI) begin
                            rhi_d = b;
                            rph_d = `PFC_PH_CRC_LO;
                        end else begin
                            rflag_d = ({rhi_q, b} == ~crc);
                            if ({rhi_q, b} == ~crc) begin
                                revt_d.payload_ready_event = 1'b1;
                                revt_d.checksum_ok_event = 1'b1;
                            end else if (cfg_i.checksum_autoclear_disable) begin
                                revt_d.payload_ready_event = 1'b1;
                            end else begin
                                revt_d.fifo_clear = 1'b1;
                            end
                            rsh_d = ~sync_exp;
                            rst_d = RX_HUNT;
                        end
                        if (discard) begin
                            revt_d.fifo_clear = 1'b1;
                            rsh_d = ~sync_exp;
                            rst_d = RX_HUNT;
                        end
                    end
                end
            end
            default: rst_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rst_q <= RX_IDLE;
            rsh_q <= 32'h00000000;
            rbyte_q <= 8'h00;
            rbit_q <= 3'h0;
            ridx_q <= 8'h00;
            rtot_q <= 8'h00;
            rph_q <= `PFC_PH_DATA;
            rhi_q <= 8'h00;
            rhalf_q <= 1'b0;
            rflag_q <= 1'b0;
            rout_q <= 8'h00;
            rval_q <= 1'b0;
            revt_q <= '0;
        end else begin
            rst_q <= rst_d;
            rsh_q <= rsh_d;
            rbyte_q <= rbyte_d;
            rbit_q <= rbit_d;
            ridx_q <= ridx_d;
            rtot_q <= rtot_d;
            rph_q <= rph_d;
            rhi_q <= rhi_d;
            rhalf_q <= rhalf_d;
            rflag_q <= rflag_d;
            rout_q <= rout_d;
            rval_q <= rval_d;
            revt_q <= revt_d;
        end
    end

    // outputs
    always_comb begin
        tx_active_o = (tst_q != TX_IDLE);
        tx_chip_o = tchip_q;
        rx_byte_o = rout_q;
        rx_byte_valid_o = rval_q;
        checksum_result_flag_o = rflag_q;
        events_o = revt_q;
        events_o.tx_done = tdone_q;
    end
endmodule

// ---- pfc_packet_handler_tb.sv ----
// Purpose: loopback bench for the packet handler
// Assumes: the modem model replays recorded tx chips into rx
// Notes: two clocks a chip keep frames short
`timescale 1ns/10ps
module pfc_packet_handler_tb;
    import pfc_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, rx_mode_i = 1'b0, tx_start_i = 1'b0;
    logic tx_byte_valid_i = 1'b0, play = 1'b0, flip = 1'b0;
    logic [7:0] tx_byte_i = 8'h00;
    pfc_cfg_t cfg_i = '0;
    logic tx_byte_ready_o, tx_chip_o, tx_active_o, rx_chip_i, rx_byte_valid_o;
    logic checksum_result_flag_o;
    logic [7:0] rx_byte_o;
    pfc_evt_t events_o;
    int fails = 0, check_count = 0;
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    pfc_packet_handler i_pfc_packet_handler (.clk_sys_i, .rst_i, .cfg_i, .rx_mode_i, .tx_start_i,
        .tx_byte_i, .tx_byte_valid_i, .tx_byte_ready_o, .tx_chip_o, .tx_active_o, .rx_chip_i,
        .rx_byte_o, .rx_byte_valid_o, .events_o, .checksum_result_flag_o);
    pfc_modem_model i_pfc_modem_model (.clk_sys_i, .rec_i(tx_active_o), .play_i(play),
        .flip_i(flip), .chip_i(tx_chip_o), .chip_o(rx_chip_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // send one frame, replay it into rx, compare events {sync,ready,ok,clear,flag} and, when ready is expected, bytes
    task automatic run(input logic [1:0] mode, input logic [7:0] addr, input logic [7:0] len,
                       input logic [1:0] dcf, input logic [1:0] err, input logic [4:0] exp);
        logic [7:0] b[$];
        logic [7:0] got[$];
        logic [4:0] ev = 5'h00;
        int k = 0;
        bit go;
        for (int i = 0; i <= len; i++) begin
            b.push_back(i == 0 ? len : (i == 1 ? addr : 8'(i * 53)));
        end
        cfg_i.address_filter_mode = mode;
        {cfg_i.biphase_coding_enable, cfg_i.scrambler_enable} = dcf;
        cfg_i.checksum_autoclear_disable = &err;
        cfg_i.sync_word_value = err == 2'b10 ? 32'hd42d0000 : 32'h2dd40000;
        flip = err[0];
        i_pfc_modem_model.clear();
        tx_start_i = 1'b1;
        tx_byte_valid_i = 1'b1;
        // bounded wait for the end of transmission
        for (int n = 0; n <= 20000; n++) begin
            tx_byte_i = k < b.size() ? b[k] : 8'h00;
            go = tx_byte_ready_o;
            @(posedge clk_sys_i);
            #2;
            tx_start_i = 1'b0;
            k += int'(go);
            if (events_o.tx_done === 1'b1) break;
            if (n == 20000) begin
                fails++;
                results();
            end
        end
        cfg_i.sync_word_value = 32'h2dd40000;
        rx_mode_i = 1'b1;
        play = 1'b1;
        repeat (i_pfc_modem_model.q.size() + 60) begin
            @(posedge clk_sys_i);
            #2;
            if (rx_byte_valid_o === 1'b1) got.push_back(rx_byte_o);
            ev[4:1] |= {events_o.sync_event, events_o.payload_ready_event,
                        events_o.checksum_ok_event, events_o.fifo_clear};
        end
        ev[0] = checksum_result_flag_o;
        rx_mode_i = 1'b0;
        play = 1'b0;
        chk(8'(ev), 8'(exp));
        if (exp[3]) begin
            chk(8'(got.size()), 8'(b.size()));
            foreach (got[i]) chk(got[i], b[i]);
        end
    endtask
    initial begin
        cfg_i.sync_match_enable = 1'b1;
        cfg_i.sync_word_size = 2'b01;
        cfg_i.variable_length = 1'b1;
        cfg_i.payload_length_limit = 7'h10;
        cfg_i.node_address = 8'h5a;
        cfg_i.checksum_enable = 1'b1;
        cfg_i.bit_rate_value = 7'h01;
        repeat (6) @(posedge clk_sys_i);
        #2 rst_i = 1'b0;
        run(2'b01, 8'h5a, 8'h03, 2'b00, 2'b00, 5'b11101);
        run(2'b10, 8'h00, 8'h03, 2'b00, 2'b00, 5'b11101);
        run(2'b11, 8'hff, 8'h03, 2'b00, 2'b00, 5'b11101);
        run(2'b01, 8'h00, 8'h03, 2'b00, 2'b00, 5'b10011);
        run(2'b10, 8'hff, 8'h03, 2'b00, 2'b00, 5'b10011);
        run(2'b00, 8'h5a, 8'h10, 2'b00, 2'b00, 5'b10011);
        run(2'b00, 8'h5a, 8'h0f, 2'b00, 2'b00, 5'b11101);
        run(2'b00, 8'h5a, 8'h03, 2'b10, 2'b00, 5'b11101);
        run(2'b00, 8'h5a, 8'h03, 2'b01, 2'b00, 5'b11101);
        run(2'b00, 8'h5a, 8'h03, 2'b00, 2'b01, 5'b10010);
        run(2'b00, 8'h5a, 8'h03, 2'b00, 2'b11, 5'b11000);
        run(2'b00, 8'h5a, 8'h03, 2'b00, 2'b10, 5'b00000);
        cfg_i.variable_length = 1'b0;
        run(2'b00, 8'h5a, 8'h0f, 2'b00, 2'b00, 5'b11101);
        results();
    end
endmodule

// ---- pfc_pkg.sv ----
// Purpose: types shared by the packet filter and codec
// Assumes: pfc_consts.svh holds the numeric constants
// Notes: configuration arrives as plain ports bundled in one struct
package pfc_pkg;

    // static configuration, held by the host side
    typedef struct packed {
        logic sync_match_enable;
        logic [1:0] sync_word_size;        // bytes minus one
        logic [1:0] sync_error_tolerance;  // bit errors allowed
        logic [31:0] sync_word_value;      // msb sent first
        logic variable_length;             // 1: length byte format
        logic [6:0] payload_length_limit;
        logic [1:0] address_filter_mode;
        logic [7:0] node_address;
        logic checksum_enable;
        logic checksum_autoclear_disable;
        logic biphase_coding_enable;
        logic scrambler_enable;
        logic [6:0] bit_rate_value;        // chip period minus one, in clocks
    } pfc_cfg_t;

    // one-cycle event pulses
    typedef struct packed {
        logic sync_event;
        logic payload_ready_event;
        logic checksum_ok_event;
        logic fifo_clear;
        logic tx_done;
    } pfc_evt_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_SYNC = 3'b001,
        TX_LOAD = 3'b010,
        TX_BITS = 3'b011,
        TX_DONE = 3'b100
    } pfc_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_HUNT = 2'b01,
        RX_BITS = 2'b10
    } pfc_rx_state_t;

endpackage
